/* File: bench/abbe_exec_tb_top.sv */
module abbe_exec_tb_top
    import abbe_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic we;
        logic [6:0] ad;
        logic [7:0] wd;
        logic [7:0] acc;
        logic c, dcf, z;
        logic [14:0] pc;
        logic fl;
    } abbe_exp_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic issue = 1'b0;
    logic dest_file = 1'b0;
    abbe_op_t op = ABBE_OP_NONE;
    logic [6:0] faddr = 7'h00;
    logic [2:0] bsel = 3'h0;
    logic [8:0] offset = 9'h000;
    logic [7:0] fdata = 8'h00;
    logic mem_we_q, carry_q, digit_carry_flag_q, zero_q, flush_q, busy_q;
    logic [6:0] mem_addr_q;
    logic [7:0] mem_wdata_q, acc_q;
    logic [14:0] pc_q;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    abbe_exp_t m = '0;
    abbe_exp_t e;
    abbe_exp_t q[$];

    abbe_exec i_abbe_exec (.clk(clk), .nrst(nrst), .issue(issue), .op(op),
        .faddr(faddr), .dest_file(dest_file), .bsel(bsel), .offset(offset),
        .fdata(fdata), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .acc_q(acc_q), .carry_q(carry_q),
        .digit_carry_flag_q(digit_carry_flag_q), .zero_q(zero_q),
        .pc_q(pc_q), .flush_q(flush_q), .busy_q(busy_q));

    always #2 clk = ~clk;

    task automatic check(string n, logic [14:0] s, logic [14:0] x);
        checks++;
        if (s !== x) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", n, x, s);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Presents one instruction and notes the state expected one edge later
    task automatic drive(abbe_op_t o, logic [8:0] k, logic [7:0] f,
                         logic [2:0] b, logic d, logic i);
        logic [8:0] s;
        logic [7:0] r;
        logic ci;
        logic wr;
        @(posedge clk);
        #1;
        i = i | m.fl;
        issue = i;
        op = o;
        offset = k;
        fdata = f;
        bsel = b;
        dest_file = d;
        faddr = 7'($urandom);
        wr = 1'b0;
        r = 8'h00;
        m.we = 1'b0;
        if (m.fl) begin
            m.fl = 1'b0;
            m.pc = m.pc + 15'h0001;
        end else if (i) begin
            m.pc = m.pc + 15'h0001;
            ci = (o == ABBE_OP_ADDC) && m.c;
            case (o)
                ABBE_OP_ADD, ABBE_OP_ADDC: begin
                    s = m.acc + f + ci;
                    m.dcf = (m.acc[3:0] + f[3:0] + ci) > 5'h0f;
                    r = s[7:0];
                    m.c = s[8];
                    wr = 1'b1;
                end
                ABBE_OP_ASR: begin
                    r = {f[7], f[7:1]};
                    m.c = f[0];
                    wr = 1'b1;
                end
                ABBE_OP_BCLR: begin
                    m.we = 1'b1;
                    m.ad = faddr;
                    m.wd = f & ~(8'h01 << b);
                end
                ABBE_OP_BTSZ: m.fl = ~f[b];
                ABBE_OP_JMP: begin
                    m.pc = m.pc + {{6{k[8]}}, k};
                    m.fl = 1'b1;
                end
                default: ;
            endcase
            if (wr) begin
                m.z = (r == 8'h00);
                if (d) begin
                    m.we = 1'b1;
                    m.ad = faddr;
                    m.wd = r;
                end else
                    m.acc = r;
            end
        end
        q.push_back(m);
    endtask

    always @(posedge clk) begin
        #0.5;
        if (q.size() > 0) begin
            e = q.pop_front();
            check("acc", 15'(acc_q), 15'(e.acc));
            check("flags", 15'({carry_q, digit_carry_flag_q, zero_q}),
                  15'({e.c, e.dcf, e.z}));
            check("mem_we", 15'(mem_we_q), 15'(e.we));
            check("mem", {mem_addr_q, mem_wdata_q}, {e.ad, e.wd});
            check("pc", pc_q, e.pc);
            check("flush", 15'({flush_q, busy_q}), 15'({2{e.fl}}));
        end
    end

    // Ceiling well above the roughly 420 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(32'hb968dd47));
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        drive(ABBE_OP_JMP, 9'h100, 8'h00, 3'h0, 1'b0, 1'b1);
        drive(ABBE_OP_ADD, 9'h000, 8'h55, 3'h0, 1'b0, 1'b1);
        drive(ABBE_OP_JMP, 9'h0ff, 8'h00, 3'h0, 1'b0, 1'b1);
        drive(ABBE_OP_ADD, 9'h000, 8'h88, 3'h0, 1'b0, 1'b1);
        drive(ABBE_OP_BTSZ, 9'h000, 8'hef, 3'h4, 1'b0, 1'b1);
        drive(ABBE_OP_ADD, 9'h000, 8'h11, 3'h0, 1'b0, 1'b1);
        drive(ABBE_OP_ADD, 9'h000, 8'h78, 3'h0, 1'b1, 1'b1);
        drive(ABBE_OP_ADDC, 9'h000, 8'h00, 3'h0, 1'b0, 1'b1);
        drive(ABBE_OP_ASR, 9'h000, 8'h81, 3'h0, 1'b1, 1'b1);
        for (int n = 0; n < 400; n++) begin
            drive(abbe_op_t'($urandom_range(6)), 9'($urandom),
                  8'($urandom), 3'($urandom), 1'($urandom),
                  $urandom_range(7) != 0);
        end
        drive(ABBE_OP_NONE, 9'h000, 8'h00, 3'h0, 1'b0, 1'b0);
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule

/* File: design/abbe_alu.sv */
module abbe_alu
    import abbe_pkg::*;
(
    // Operation and operands
    input wire abbe_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] fval,
    input wire logic [2:0] bsel,
    input wire logic cin,
    // Results
    output logic [7:0] res,
    output logic cout,
    output logic dcout
);
    logic [8:0] sum;
    logic [4:0] low;
    logic ci;
    always_comb begin
        ci = (op == ABBE_OP_ADDC) ? cin : 1'b0;
        sum = {1'b0, acc} + {1'b0, fval} + {8'h00, ci};
        low = {1'b0, acc[3:0]} + {1'b0, fval[3:0]} + {4'h0, ci};
        res = sum[7:0];
        cout = sum[8];
        dcout = low[ABBE_NIB];
        case (op)
            ABBE_OP_ASR: begin
                res = {fval[7], fval[7:1]};
                cout = fval[0];
                dcout = 1'b0;
            end
            ABBE_OP_BCLR: begin
                res = fval & ~(8'h01 << bsel);
            end
            default: begin
            end
        endcase
    end
endmodule

/* File: design/abbe_exec.sv */
// Notes on behaviour
// - Sum acc and file register to chosen target; carry, digit carry, zero.
// - Arithmetic right shift keeps bit 7; old bit 0 to carry; C, Z only.
// - Add with carry adds current carry; same target and flags as add.
// - Bit clear zeroes the selected bit only; no flags change.
// - Bit test: bit zero skips next instruction as a nop, two cycles.
// - Relative jump: new PC is PC + 1 + sign-extended 9-bit offset.
// - Relative jump takes two cycles to flush the fetched instruction.
// - PC change or taken skip spends a second nop cycle.
module abbe_exec
    import abbe_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Decoded instruction
    input wire logic issue,
    input wire abbe_op_t op,
    input wire logic [6:0] faddr,
    input wire logic dest_file,
    input wire logic [2:0] bsel,
    input wire logic [8:0] offset,
    input wire logic [7:0] fdata,
    // Data memory write
    output logic mem_we_q,
    output logic [6:0] mem_addr_q,
    output logic [7:0] mem_wdata_q,
    // Core state
    output logic [7:0] acc_q,
    output logic carry_q,
    output logic digit_carry_flag_q,
    output logic zero_q,
    output logic [14:0] pc_q,
    output logic flush_q,
    output logic busy_q
);
    logic [7:0] res;
    logic cout;
    logic dcout;
    logic mem_we_d;
    logic [6:0] mem_addr_d;
    logic [7:0] mem_wdata_d;
    logic [7:0] acc_d;
    logic carry_d;
    logic dcf_d;
    logic zero_d;
    logic [14:0] pc_d;
    logic flush_d;
    logic take;

    abbe_alu i_abbe_alu (
        .op(op),
        .acc(acc_q),
        .fval(fdata),
        .bsel(bsel),
        .cin(carry_q),
        .res(res),
        .cout(cout),
        .dcout(dcout)
    );

    function automatic logic [14:0] jump_target(input logic [14:0] pc,
                                                input logic [8:0] ofs);
        logic [14:0] ext;
        ext = {{(ABBE_PC_W - ABBE_OFS_W){ofs[8]}}, ofs};
        return pc + 15'h0001 + ext;
    endfunction

    // An issue during the flush cycle is the discarded fetch and is ignored
    assign take = issue && !flush_q;

    always_comb begin
        mem_we_d = 1'b0;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        acc_d = acc_q;
        carry_d = carry_q;
        dcf_d = digit_carry_flag_q;
        zero_d = zero_q;
        pc_d = pc_q;
        flush_d = 1'b0;
        if (take) begin
            pc_d = pc_q + 15'h0001;
            case (op)
                ABBE_OP_ADD, ABBE_OP_ADDC, ABBE_OP_ASR: begin
                    if (dest_file) begin
                        mem_we_d = 1'b1;
                        mem_addr_d = faddr;
                        mem_wdata_d = res;
                    end else begin
                        acc_d = res;
                    end
                    carry_d = cout;
                    if (op != ABBE_OP_ASR) begin
                        dcf_d = dcout;
                    end
                    zero_d = (res == 8'h00);
                end
                ABBE_OP_BCLR: begin
                    mem_we_d = 1'b1;
                    mem_addr_d = faddr;
                    mem_wdata_d = res;
                end
                ABBE_OP_BTSZ: begin
                    flush_d = !fdata[bsel];
                end
                ABBE_OP_JMP: begin
                    pc_d = jump_target(pc_q, offset);
                    flush_d = 1'b1;
                end
                default: begin
                end
            endcase
        end else if (issue) begin
            pc_d = pc_q + 15'h0001; // Discarded slot still advances fetch
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_we_q <= 1'b0;
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
            acc_q <= ABBE_ACC_RST;
            carry_q <= 1'b0;
            digit_carry_flag_q <= 1'b0;
            zero_q <= 1'b0;
            pc_q <= ABBE_PC_RST;
            flush_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            mem_we_q <= mem_we_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
            acc_q <= acc_d;
            carry_q <= carry_d;
            digit_carry_flag_q <= dcf_d;
            zero_q <= zero_d;
            pc_q <= pc_d;
            flush_q <= flush_d;
            busy_q <= flush_d;
        end
    end

    a_add_sum: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_ADD && !dest_file |=>
        acc_q == $past(acc_q) + $past(fdata))
        else $error("add result wrong");
    a_add_dest: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_ADD && dest_file |=>
        mem_we_q && mem_addr_q == $past(faddr) && acc_q == $past(acc_q))
        else $error("add destination wrong");
    a_asr_shift: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_ASR && dest_file |=>
        mem_wdata_q == {$past(fdata[7]), $past(fdata[7:1])}
        && carry_q == $past(fdata[0])
        && digit_carry_flag_q == $past(digit_carry_flag_q))
        else $error("shift wrong");
    a_asr_acc: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_ASR && !dest_file |=>
        acc_q == {$past(fdata[7]), $past(fdata[7:1])}
        && zero_q == (acc_q == 8'h00) && !mem_we_q)
        else $error("shift to accumulator wrong");
    a_addc_sum: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_ADDC && !dest_file |=>
        {carry_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(fdata)}
        + {8'h00, $past(carry_q)})
        else $error("add with carry wrong");
    a_bclr_bit: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_BCLR |=>
        mem_wdata_q[$past(bsel)] == 1'b0 && zero_q == $past(zero_q)
        && carry_q == $past(carry_q))
        else $error("bit clear wrong");
    a_bclr_keep: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_BCLR |=>
        (mem_wdata_q | (8'h01 << $past(bsel)))
        == ($past(fdata) | (8'h01 << $past(bsel)))
        && digit_carry_flag_q == $past(digit_carry_flag_q))
        else $error("bit clear touched other bits");
    a_skip_nop: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_BTSZ && !fdata[bsel] |=>
        flush_q ##1 !flush_q)
        else $error("skip not two cycles");
    a_noskip: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_BTSZ && fdata[bsel] |=> !flush_q)
        else $error("skip taken on set bit");
    a_skip_flags: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_BTSZ |=> !mem_we_q
        && {carry_q, digit_carry_flag_q, zero_q}
        == $past({carry_q, digit_carry_flag_q, zero_q}))
        else $error("bit test changed state");
    a_jump_pc: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_JMP |=>
        pc_q == $past(pc_q) + 15'h0001
        + {{6{$past(offset[8])}}, $past(offset)})
        else $error("jump target wrong");
    a_jump_flags: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_JMP |=> !mem_we_q
        && {carry_q, digit_carry_flag_q, zero_q}
        == $past({carry_q, digit_carry_flag_q, zero_q}))
        else $error("jump changed state");
    a_jump_flush: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_JMP ##1 issue |=>
        !mem_we_q && acc_q == $past(acc_q))
        else $error("flushed slot had effect");
    a_discard_pc: assert property (
        @(posedge clk) disable iff (!nrst)
        flush_q && issue |=>
        pc_q == $past(pc_q) + 15'h0001 && !flush_q)
        else $error("discarded slot wrong");
    a_zero_flag: assert property (
        @(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_ADD && !dest_file |=>
        zero_q == (acc_q == 8'h00))
        else $error("zero flag wrong");

    c_skip: cover property (@(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_BTSZ && !fdata[bsel]);
    c_jump_back: cover property (@(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_JMP && offset[8]);
    c_add_carry: cover property (@(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_ADDC && carry_q);
    c_file_write: cover property (@(posedge clk) disable iff (!nrst)
        take && dest_file && op == ABBE_OP_ASR);
    c_zero_sum: cover property (@(posedge clk) disable iff (!nrst)
        take && op == ABBE_OP_ADD && res == 8'h00);
endmodule

/* File: inc/abbe_pkg.sv */
package abbe_pkg;
    localparam int ABBE_DATA_W = 8;
    localparam int ABBE_ADDR_W = 7;
    localparam int ABBE_PC_W = 15;
    localparam int ABBE_OFS_W = 9;
    localparam logic [6:0] ABBE_ADDR_MAX = 7'h7f;
    localparam logic [2:0] ABBE_BIT_MAX = 3'h7;
    localparam int ABBE_NIB = 4;
    localparam logic [14:0] ABBE_PC_RST = 15'h0000;
    localparam logic [7:0] ABBE_ACC_RST = 8'h00;
    localparam int ABBE_FLUSH_CYC = 2;
    typedef enum logic [2:0] {
        ABBE_OP_NONE,
        ABBE_OP_ADD,
        ABBE_OP_ADDC,
        ABBE_OP_ASR,
        ABBE_OP_BCLR,
        ABBE_OP_BTSZ,
        ABBE_OP_JMP
    } abbe_op_t;
endpackage
